//--- design/icc_installer.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// - Reader command takes two codes; 00 disables, 01 enables each terminal.
// - Card-reader variant: each terminal code selects its transmission format.
// - Codes 20,25,21,22,23,18 are the parity-free formats.
// - Any reader terminal or extension enabled frees clock/data lines from outputs.
// - Card terminal zero takes input lines one/two, terminal one lines three/four.
// - Extension module enable 0/1, disabled after reset.
// - Unlock seconds 00..99, default 04; 00 means latch operation.
// - Open timeout 01..99, default 09; ajar alarm only with door contact.
// - Identification mode 0..3: card or PIN, card, PIN, card and PIN.
// - Block after five wrong logins, option 0/1, off after reset.
// - Duress option inverted: 1 deactivates, 0 activates, default 0.
// - Site code is card bits 16..23; matching grants every such card.
// - Reduced code is first 24 card bits; site part ranges 0..255.
// - Auto-relock 0 off, 1 on opening, 2 on closing, default 0.
// - Per user command 10..39 auth flag, default 1; star form sets all.
// - Door alarm on internal sounder option 0/1, off after reset.
// - Four function keys store function 00..83 and auth bit default 1.
// - New master/installer credential replaces old; master card acts as installer card until one is stored.
// - Passback mode 0/1/2 default 0, plus separate strict bit.
// - Aux one, aux two, light timers 00..99 s, 00 makes flag latching.
// - Good command gives three beeps, bad one long beep; mode stays.
// - Leave mode after 4 minutes idle or on exit command.
module icc_installer
  import icc_pkg::*;
#(
  parameter longint unsigned IDLE_LIMIT = IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enter_request,
  input wire logic key_valid,
  input wire logic [3:0] key_code,
  input wire logic cred_valid,
  input wire logic cred_is_pin,
  input wire logic [31:0] cred_value,
  input wire logic card_reader_variant,
  input wire logic door_contact_present,
  input wire logic card_valid,
  input wire logic [39:0] card_code,
  output icc_cfg_s cfg,
  output logic installer_mode,
  output logic beep_ok,
  output logic beep_err,
  output logic gpo_release,
  output logic input_line_one_off,
  output logic input_line_two_off,
  output logic input_line_three_off,
  output logic input_line_four_off,
  output logic [1:0] rdr_no_parity,
  output logic latch_mode,
  output logic ajar_alarm_allowed,
  output logic duress_active,
  output logic [2:0] flag_latching,
  output logic [23:0] reduced_code,
  output logic site_grant,
  output logic [31:0] master_card,
  output logic [31:0] master_pin,
  output logic [31:0] installer_card,
  output logic [31:0] installer_pin
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [6:0] dec2(input logic [3:0] hi, input logic [3:0] lo);
    dec2 = 7'({3'h0, hi} * 7'd10 + {3'h0, lo});
  endfunction

  function automatic logic fmt_ok(input logic [6:0] c, input logic wg);
    if (!wg) begin
      fmt_ok = (c <= 7'd1);
    end else begin
      case (c)
        7'd0, 7'd3, 7'd4, 7'd5, 7'd15, 7'd16, 7'd17, 7'd18: fmt_ok = 1'b1;
        7'd20, 7'd21, 7'd22, 7'd23, 7'd24, 7'd25: fmt_ok = 1'b1;
        default: fmt_ok = 1'b0;
      endcase
    end
  endfunction

  function automatic logic no_parity(input logic [4:0] c);
    case (c)
      5'd18, 5'd20, 5'd21, 5'd22, 5'd23, 5'd25: no_parity = 1'b1;
      default: no_parity = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Key collection
  // ----------------------------------------
  icc_state_e state_reg;
  logic [3:0] dig_reg [DIG_N];
  logic [3:0] cnt_reg;
  logic ovf_reg;
  logic [1:0] cred_sel_reg;
  logic [35:0] idle_reg;
  logic hash_hit;
  logic digit_hit;
  logic idle_out;

  assign hash_hit = key_valid && (state_reg == ST_KEYS) && (key_code == KEY_HASH);
  assign digit_hit = key_valid && (state_reg == ST_KEYS) && (key_code != KEY_HASH)
                     && (key_code <= KEY_STAR);
  assign idle_out = (state_reg != ST_OFF) && (idle_reg >= 36'(IDLE_LIMIT - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      ovf_reg <= 1'b0;
      for (int i = 0; i < DIG_N; i++) begin
        dig_reg[i] <= 4'h0;
      end
    end else if (hash_hit || state_reg != ST_KEYS) begin
      cnt_reg <= 4'h0;
      ovf_reg <= 1'b0;
    end else if (digit_hit) begin
      if (cnt_reg == DIG_N) begin
        ovf_reg <= 1'b1;
      end else begin
        dig_reg[cnt_reg[2:0]] <= key_code;
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  icc_cfg_s cfg_next;
  logic cmd_ok;
  logic cmd_exit;
  logic cred_go;
  logic star2;
  logic bad_star;
  logic [6:0] cmd;
  logic [6:0] pa;
  logic [6:0] pb;
  logic [6:0] pm;
  logic [4:0] uidx;

  always_comb begin
    cfg_next = cfg;
    cmd_ok = 1'b0;
    cmd_exit = 1'b0;
    cred_go = 1'b0;
    cmd = dec2(dig_reg[0], dig_reg[1]);
    pa = dec2(dig_reg[2], dig_reg[3]);
    pb = dec2(dig_reg[4], dig_reg[5]);
    pm = dec2(dig_reg[3], dig_reg[4]);
    uidx = 5'(pa - UCMD_LO);
    star2 = (dig_reg[2] == KEY_STAR) && (cnt_reg > 4'h2);
    bad_star = ovf_reg;
    for (int i = 0; i < DIG_N; i++) begin
      if (4'(i) < cnt_reg && dig_reg[i] > MAX_DIGIT && i != 2) begin
        bad_star = 1'b1;
      end
    end
    if (!bad_star) begin
      case (cmd)
        7'd0: begin
          cmd_ok = (cnt_reg == 4'h2);
          cmd_exit = cmd_ok;
        end
        7'd61: begin
          if (cnt_reg == 4'h6 && !star2 && fmt_ok(pa, card_reader_variant)
              && fmt_ok(pb, card_reader_variant)) begin
            cmd_ok = 1'b1;
            cfg_next.rdr0_fmt = pa[4:0];
            cfg_next.rdr1_fmt = pb[4:0];
          end
        end
        7'd62: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.ext_en = dig_reg[2][0];
          end
        end
        7'd63: begin
          if (cnt_reg == 4'h4 && !star2 && pa <= MAX_TWO) begin
            cmd_ok = 1'b1;
            cfg_next.unlock_seconds = pa;
          end
        end
        7'd64: begin
          if (cnt_reg == 4'h4 && !star2 && pa >= 7'd1) begin
            cmd_ok = 1'b1;
            cfg_next.open_timeout_seconds = pa;
          end
        end
        7'd65: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h3) begin
            cmd_ok = 1'b1;
            cfg_next.id_mode = dig_reg[2][1:0];
          end
        end
        7'd66: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.block_en = dig_reg[2][0];
          end
        end
        7'd67: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.duress_off = dig_reg[2][0];
          end
        end
        7'd68: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h2) begin
            cmd_ok = 1'b1;
            cfg_next.relock = dig_reg[2][1:0];
          end
        end
        7'd69: begin
          if (star2 && cnt_reg == 4'h4 && dig_reg[3] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.ucmd_auth = {30{dig_reg[3][0]}};
          end else if (!star2 && cnt_reg == 4'h5 && pa >= UCMD_LO && pa <= UCMD_HI
                       && dig_reg[4] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.ucmd_auth[uidx] = dig_reg[4][0];
          end
        end
        7'd70: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.alarm_en = dig_reg[2][0];
          end
        end
        7'd71, 7'd72, 7'd73, 7'd74: begin
          if (cnt_reg == 4'h5 && !star2 && pa <= MAX_KEY_FN && dig_reg[4] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.key_function_number[cmd[1:0] - 2'd3] = pa;
            cfg_next.key_auth[cmd[1:0] - 2'd3] = dig_reg[4][0];
          end
        end
        7'd75, 7'd76, 7'd77, 7'd78: begin
          cred_go = (cnt_reg == 4'h2);
        end
        7'd79: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h2) begin
            cmd_ok = 1'b1;
            cfg_next.apb_mode = dig_reg[2][1:0];
          end
        end
        7'd80: begin
          if (cnt_reg == 4'h3 && dig_reg[2] <= 4'h1) begin
            cmd_ok = 1'b1;
            cfg_next.strict_passback_bit = dig_reg[2][0];
          end
        end
        7'd81, 7'd82, 7'd83: begin
          if (!star2 && cnt_reg == 4'h4) begin
            cmd_ok = 1'b1;
            cfg_next.flag_time[cmd[1:0] - 2'd1] = pa;
            cfg_next.flag_minutes[cmd[1:0] - 2'd1] = 1'b0;
          end else if (star2 && cnt_reg == 4'h5 && pm >= 7'd1) begin
            cmd_ok = 1'b1;
            cfg_next.flag_time[cmd[1:0] - 2'd1] = pm;
            cfg_next.flag_minutes[cmd[1:0] - 2'd1] = 1'b1;
          end
        end
        default: cmd_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Mode sequencing
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
      cred_sel_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (enter_request) begin
            state_reg <= ST_KEYS;
          end
        end
        ST_KEYS: begin
          if (idle_out || (hash_hit && cmd_exit)) begin
            state_reg <= ST_OFF;
          end else if (hash_hit && cred_go) begin
            state_reg <= ST_CRED;
            cred_sel_reg <= cmd[1:0] - 2'd3;
          end
        end
        ST_CRED: begin
          if (idle_out) begin
            state_reg <= ST_OFF;
          end else if (cred_valid || key_valid) begin
            state_reg <= ST_KEYS;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= 36'h0;
    end else if (state_reg == ST_OFF || key_valid || cred_valid) begin
      idle_reg <= 36'h0;
    end else begin
      idle_reg <= idle_reg + 36'h1;
    end
  end

  // ----------------------------------------
  // Settings and credentials
  // ----------------------------------------
  logic cred_take;
  logic cred_kind_ok;
  logic inst_card_def_reg;
  logic [31:0] inst_card_reg;

  assign cred_take = (state_reg == ST_CRED) && cred_valid && !idle_out;
  assign cred_kind_ok = (cred_is_pin == cred_sel_reg[0]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RST;
    end else if (hash_hit && cmd_ok && !idle_out) begin
      cfg <= cfg_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_card <= 32'h0;
      master_pin <= 32'h0;
      inst_card_reg <= 32'h0;
      inst_card_def_reg <= 1'b0;
      installer_pin <= 32'h0;
    end else if (cred_take && cred_kind_ok) begin
      case (cred_sel_reg)
        2'd0: master_card <= cred_value;
        2'd1: master_pin <= cred_value;
        2'd2: begin
          inst_card_reg <= cred_value;
          inst_card_def_reg <= 1'b1;
        end
        default: installer_pin <= cred_value;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      installer_card <= 32'h0;
    end else begin
      installer_card <= inst_card_def_reg ? inst_card_reg : master_card;
    end
  end

  // ----------------------------------------
  // Signals and derived outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beep_ok <= 1'b0;
      beep_err <= 1'b0;
      installer_mode <= 1'b0;
    end else begin
      beep_ok <= (hash_hit && cmd_ok && !idle_out) || (cred_take && cred_kind_ok);
      beep_err <= (hash_hit && !cmd_ok && !cred_go && !idle_out)
                  || (cred_take && !cred_kind_ok)
                  || ((state_reg == ST_CRED) && key_valid && !cred_valid);
      installer_mode <= (state_reg != ST_OFF);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpo_release <= 1'b0;
      input_line_one_off <= 1'b0;
      input_line_two_off <= 1'b0;
      input_line_three_off <= 1'b0;
      input_line_four_off <= 1'b0;
      rdr_no_parity <= 2'b00;
      latch_mode <= 1'b0;
      ajar_alarm_allowed <= 1'b0;
      duress_active <= 1'b0;
      flag_latching <= 3'b000;
    end else begin
      gpo_release <= (cfg.rdr0_fmt != 5'h0) || (cfg.rdr1_fmt != 5'h0) || cfg.ext_en;
      input_line_one_off <= card_reader_variant && (cfg.rdr0_fmt != 5'h0);
      input_line_two_off <= card_reader_variant && (cfg.rdr0_fmt != 5'h0);
      input_line_three_off <= card_reader_variant && (cfg.rdr1_fmt != 5'h0);
      input_line_four_off <= card_reader_variant && (cfg.rdr1_fmt != 5'h0);
      rdr_no_parity <= {no_parity(cfg.rdr1_fmt), no_parity(cfg.rdr0_fmt)};
      latch_mode <= (cfg.unlock_seconds == 7'h0);
      ajar_alarm_allowed <= door_contact_present;
      duress_active <= !cfg.duress_off;
      for (int i = 0; i < 3; i++) begin
        flag_latching[i] <= (cfg.flag_time[i] == 7'h0) && !cfg.flag_minutes[i];
      end
    end
  end

  // ----------------------------------------
  // Site code match
  // ----------------------------------------
  logic [15:0] ctrl_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reduced_code <= 24'h0;
      site_grant <= 1'b0;
    end else begin
      site_grant <= card_valid && ctrl_reg[CTRL_SITE_EN_BIT]
                    && (card_code[23:16] == ctrl_reg[CTRL_SITE_LSB +: 8]);
      if (card_valid) begin
        reduced_code <= card_code[23:0];
      end
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    case ({avs_address[4:2], 2'b00})
      OFF_CTRL: rd_mux = {16'h0, ctrl_reg};
      OFF_STATUS: rd_mux = {26'h0, cred_sel_reg, state_reg, beep_err, beep_ok};
      OFF_CFG0: rd_mux = {3'h0, cfg.rdr0_fmt, cfg.rdr1_fmt, cfg.ext_en,
                          cfg.unlock_seconds, cfg.open_timeout_seconds, 4'h0};
      OFF_CFG1: rd_mux = {21'h0, cfg.id_mode, cfg.block_en, cfg.duress_off,
                          cfg.relock, cfg.alarm_en, cfg.apb_mode, cfg.strict_passback_bit, 1'b0};
      OFF_AUTH: rd_mux = {2'h0, cfg.ucmd_auth};
      OFF_KEYS: rd_mux = {cfg.key_function_number, cfg.key_auth};
      OFF_FLAGS: rd_mux = {8'h0, cfg.flag_time, cfg.flag_minutes};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_mux : 32'h0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 16'h0;
    end else if (avs_write && !avs_waitrequest && avs_address[4:2] == OFF_CTRL[4:2]) begin
      if (avs_byteenable[0]) begin
        ctrl_reg[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        ctrl_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end
endmodule

//--- design/icc_pkg.sv
package icc_pkg;
  // ----------------------------------------
  // Keypad codes and buffer
  // ----------------------------------------
  localparam logic [3:0] KEY_STAR = 4'ha;
  localparam logic [3:0] KEY_HASH = 4'hb;
  localparam logic [3:0] DIG_N = 4'h8;
  localparam logic [3:0] MAX_DIGIT = 4'h9;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CFG0 = 5'h08;
  localparam logic [4:0] OFF_CFG1 = 5'h0c;
  localparam logic [4:0] OFF_AUTH = 5'h10;
  localparam logic [4:0] OFF_KEYS = 5'h14;
  localparam logic [4:0] OFF_FLAGS = 5'h18;
  localparam int CTRL_SITE_EN_BIT = 0;
  localparam int CTRL_SITE_LSB = 8;
  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic [6:0] UNLOCK_RST = 7'h04;
  localparam logic [6:0] OPEN_RST = 7'h09;
  localparam logic [6:0] MAX_TWO = 7'h63;
  localparam logic [6:0] MAX_KEY_FN = 7'h53;
  localparam logic [6:0] UCMD_LO = 7'h0a;
  localparam logic [6:0] UCMD_HI = 7'h27;
  // ----------------------------------------
  // Idle exit timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned IDLE_EXIT_S = 240;
  localparam longint unsigned IDLE_CYCLES = IDLE_EXIT_S * CLK_HZ;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_KEYS = 2'b01,
    ST_CRED = 2'b11
  } icc_state_e;
  typedef struct packed {
    logic [4:0] rdr0_fmt;
    logic [4:0] rdr1_fmt;
    logic ext_en;
    logic [6:0] unlock_seconds;
    logic [6:0] open_timeout_seconds;
    logic [1:0] id_mode;
    logic block_en;
    logic duress_off;
    logic [1:0] relock;
    logic alarm_en;
    logic [1:0] apb_mode;
    logic strict_passback_bit;
    logic [29:0] ucmd_auth;
    logic [3:0][6:0] key_function_number;
    logic [3:0] key_auth;
    logic [2:0][6:0] flag_time;
    logic [2:0] flag_minutes;
  } icc_cfg_s;
  localparam icc_cfg_s CFG_RST = '{
    rdr0_fmt: 5'h00, rdr1_fmt: 5'h00, ext_en: 1'b0,
    unlock_seconds: UNLOCK_RST, open_timeout_seconds: OPEN_RST,
    id_mode: 2'h0, block_en: 1'b0, duress_off: 1'b0, relock: 2'h0,
    alarm_en: 1'b0, apb_mode: 2'h0, strict_passback_bit: 1'b0,
    ucmd_auth: 30'h3fffffff, key_function_number: 28'h0000000,
    key_auth: 4'hf, flag_time: 21'h000000, flag_minutes: 3'h0};
endpackage

//--- verification/icc_chk.sv
`timescale 1ns/1ps
module icc_chk
  import icc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic key_valid,
  input wire logic cred_valid,
  input wire logic card_valid,
  input wire logic [39:0] card_code,
  input wire logic card_reader_variant,
  input wire logic door_contact_present,
  input wire icc_cfg_s cfg,
  input wire logic beep_ok,
  input wire logic beep_err,
  input wire logic gpo_release,
  input wire logic input_line_one_off,
  input wire logic input_line_two_off,
  input wire logic input_line_three_off,
  input wire logic input_line_four_off,
  input wire logic [1:0] rdr_no_parity,
  input wire logic latch_mode,
  input wire logic ajar_alarm_allowed,
  input wire logic duress_active,
  input wire logic [2:0] flag_latching,
  input wire logic [23:0] reduced_code
);
  // ----
  // Settled-after-reset gate and properties
  // ----
  logic [1:0] age_reg;
  logic v;
  assign v = card_reader_variant;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  function automatic logic np(input logic [4:0] f);
    return f inside {5'h12, 5'h14, 5'h15, 5'h16, 5'h17, 5'h19};
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_beep_single: assert property (!(beep_ok && beep_err))
    else $error("both beeps high");
  a_beep_cause: assert property ((beep_ok || beep_err) |-> $past(key_valid) || $past(cred_valid))
    else $error("beep without key");
  a_latch_mode: assert property (age_reg == 2'h3 && $stable(cfg.unlock_seconds) |->
    latch_mode == (cfg.unlock_seconds == 7'h00)) else $error("latch mode wrong");
  a_gpo_release: assert property (age_reg == 2'h3 && $stable(cfg) |-> gpo_release ==
    (cfg.rdr0_fmt != 5'h00 || cfg.rdr1_fmt != 5'h00 || cfg.ext_en)) else $error("gpo wrong");
  a_line_release: assert property (age_reg == 2'h3 && $stable(cfg) && $stable(v) |->
    {input_line_four_off, input_line_three_off, input_line_two_off, input_line_one_off} ==
    {{2{v && cfg.rdr1_fmt != 5'h00}}, {2{v && cfg.rdr0_fmt != 5'h00}}})
    else $error("input lines wrong");
  a_parity_free: assert property (age_reg == 2'h3 && $stable(cfg) && $stable(v) |->
    rdr_no_parity == {v && np(cfg.rdr1_fmt), v && np(cfg.rdr0_fmt)}) else $error("parity wrong");
  a_duress_inv: assert property (age_reg == 2'h3 && $stable(cfg.duress_off) |->
    duress_active == !cfg.duress_off) else $error("duress wrong");
  a_ajar_follow: assert property (age_reg == 2'h3 |->
    ajar_alarm_allowed == $past(door_contact_present)) else $error("ajar wrong");
  a_flag_latch: assert property (age_reg == 2'h3 && $stable(cfg.flag_time) |->
    flag_latching == {cfg.flag_time[2] == 7'h00, cfg.flag_time[1] == 7'h00,
    cfg.flag_time[0] == 7'h00}) else $error("flag latch wrong");
  a_reduced_code: assert property (card_valid |=> reduced_code == $past(card_code[23:0]))
    else $error("reduced code wrong");
  a_cfg_range: assert property (cfg.unlock_seconds <= MAX_TWO && cfg.relock != 2'h3 &&
    cfg.open_timeout_seconds inside {[7'h01:MAX_TWO]} && cfg.apb_mode != 2'h3)
    else $error("setting out of range");
  c_ok: cover property (beep_ok);
  c_err: cover property (beep_err);
  c_latch: cover property (latch_mode);
endmodule

//--- verification/icc_keypad.sv
`timescale 1ns/1ps
module icc_keypad
  import icc_pkg::*;
(
  input wire logic clk,
  output logic key_valid,
  output logic [3:0] key_code,
  output logic cred_valid,
  output logic cred_is_pin,
  output logic [31:0] cred_value
);
  // ----
  // Installer at the keypad; idle lines show inverted data
  // ----
  initial begin
    {key_valid, key_code, cred_valid, cred_is_pin, cred_value} = 39'h0;
  end
  task automatic press(input logic [3:0] k);
    @(posedge clk);
    key_valid <= 1'b1;
    key_code <= k;
    @(posedge clk);
    key_valid <= 1'b0;
    key_code <= ~k;
  endtask
  task automatic run(input string s);
    for (int i = 0; i < s.len(); i++) begin
      press(s[i] == "*" ? KEY_STAR : 4'(s[i] - "0"));
    end
    press(KEY_HASH);
  endtask
  task automatic cred(input logic p, input logic [31:0] v);
    @(posedge clk);
    cred_valid <= 1'b1;
    cred_is_pin <= p;
    cred_value <= v;
    @(posedge clk);
    cred_valid <= 1'b0;
    cred_value <= ~v;
  endtask
endmodule

//--- verification/test_installer_config_commands.sv
`timescale 1ns/1ps
module test_installer_config_commands
  import icc_pkg::*;
;
  // ----
  // Design, installer model and bus tasks
  // ----
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, enter_request, key_valid;
  logic cred_valid, cred_is_pin, card_reader_variant, door_contact_present, card_valid;
  logic installer_mode, beep_ok, beep_err, gpo_release, latch_mode, site_grant;
  logic input_line_one_off, input_line_two_off, input_line_three_off, input_line_four_off;
  logic ajar_alarm_allowed, duress_active;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, cred_value, d;
  logic [31:0] master_card, master_pin, installer_card, installer_pin;
  logic [3:0] avs_byteenable, key_code;
  logic [39:0] card_code;
  logic [1:0] rdr_no_parity;
  logic [2:0] flag_latching;
  logic [23:0] reduced_code;
  icc_cfg_s cfg;
  int miscompares = 0, compares = 0, n;
  string cmds[22] = '{"6307", "6400", "6499", "653", "654", "671", "682", "683", "69*0",
    "69151", "621", "612118", "71841", "71830", "792", "801", "81*05", "8200", "99", "6300",
    "661", "701"};
  logic [21:0] oks = 22'h3bef6d;
  icc_installer #(.IDLE_LIMIT(200)) u_icc_installer (.*);
  icc_keypad u_icc_keypad (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    wrap_up();
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hang();
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic beep(input logic ok);
    n = 0;
    while (beep_ok !== 1'b1 && beep_err !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) hang();
    chk(128'(beep_ok), 128'(ok));
  endtask
  task automatic enter();
    @(posedge clk);
    enter_request <= 1'b1;
    @(posedge clk);
    enter_request <= 1'b0;
    n = 0;
    while (installer_mode !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    if (n >= 10) hang();
  endtask
  initial begin
    {reset_n, avs_read, avs_write, enter_request, card_valid, door_contact_present} = 6'h0;
    {avs_address, avs_writedata, card_code} = 77'h0;
    avs_byteenable = 4'hf;
    card_reader_variant = 1'b1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(128'(cfg), 128'(CFG_RST));
    chk(128'(installer_card), 128'h0);
    bus(1'b0, OFF_CFG0, 32'h0);
    chk(128'(d), 128'h2090);
    bus(1'b0, OFF_AUTH, 32'h0);
    chk(128'(d), 128'h3fffffff);
    $display("reset values done");
    door_contact_present <= 1'b1;
    enter();
    for (int i = 0; i < 22; i++) begin
      u_icc_keypad.run(cmds[i]);
      beep(oks[i]);
    end
    chk(128'(installer_mode), 128'h1);
    chk(128'({cfg.unlock_seconds, cfg.open_timeout_seconds, cfg.id_mode, cfg.duress_off,
      cfg.relock}), 128'({7'h00, 7'h63, 2'h3, 1'b1, 2'h2}));
    chk(128'({cfg.ucmd_auth, cfg.ext_en, cfg.rdr0_fmt, cfg.rdr1_fmt, rdr_no_parity}),
      128'({30'h20, 1'b1, 5'h15, 5'h12, 2'h3}));
    chk(128'({cfg.key_function_number[0], cfg.key_auth, cfg.apb_mode, cfg.strict_passback_bit,
      cfg.block_en, cfg.alarm_en}), 128'({7'h53, 4'he, 2'h2, 3'h7}));
    chk(128'({cfg.flag_time, cfg.flag_minutes, flag_latching}), 128'({21'h5, 3'h1, 3'h6}));
    $display("command table done");
    u_icc_keypad.run("75");
    u_icc_keypad.cred(1'b0, 32'h1234);
    beep(1'b1);
    @(negedge clk);
    chk(128'(installer_card), 128'h1234);
    u_icc_keypad.run("77");
    u_icc_keypad.cred(1'b0, 32'h55);
    beep(1'b1);
    u_icc_keypad.run("76");
    u_icc_keypad.cred(1'b0, 32'h9);
    beep(1'b0);
    u_icc_keypad.run("78");
    u_icc_keypad.cred(1'b1, 32'h77);
    beep(1'b1);
    chk(128'({master_card, installer_card, master_pin, installer_pin}),
      128'({32'h1234, 32'h55, 32'h0, 32'h77}));
    $display("credentials done");
    bus(1'b1, OFF_CTRL, 32'h4201);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      card_valid <= 1'b1;
      card_code <= {16'h0, 8'h42 + 8'(i), 16'h1234};
      @(posedge clk);
      card_valid <= 1'b0;
      @(negedge clk);
      chk(128'(site_grant), 128'(i == 0));
    end
    $display("site code done");
    u_icc_keypad.run("00");
    beep(1'b1);
    repeat (3) @(negedge clk);
    chk(128'(installer_mode), 128'h0);
    enter();
    n = 0;
    while (installer_mode === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(128'(n > 150 && n < 260), 128'h1);
    $display("exit done");
    wrap_up();
  end
  initial begin
    repeat (50000) @(posedge clk);
    hang();
  end
endmodule
bind icc_installer icc_chk u_icc_chk (.*);
